// *** hw/temp_avg.sv ***
// Running average of measurement words over a power-of-two count.
// Assumes one sample pulse per completed measurement cycle.
`timescale 1ns/1ps
`default_nettype none
module temp_avg #(
   parameter int W     = 12,
   parameter int COUNT = 16
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_n,
   // Samples
   input  wire logic         bypass,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   // Result
   output logic              out_valid,
   output logic [W-1:0]      out_data
);
   localparam int CW = $clog2(COUNT);
   // Readings are signed; sign-extend so a window spanning zero averages right
   logic signed [W+CW-1:0] acc, next_acc;
   logic [CW-1:0]   cnt, next_cnt;
   logic            next_out_valid;
   logic [W-1:0]    next_out_data;

   always_comb begin
      next_acc       = acc;
      next_cnt       = cnt;
      next_out_valid = 1'b0;
      next_out_data  = out_data;
      if (in_valid) begin
         if (bypass) begin
            next_out_valid = 1'b1;
            next_out_data  = in_data;
            next_acc       = '0;
            next_cnt       = '0;
         end else if (cnt == CW'(COUNT - 1)) begin
            next_out_valid = 1'b1;
            next_out_data  = W'((acc + (W+CW)'(signed'(in_data))) >>> CW);
            next_acc       = '0;
            next_cnt       = '0;
         end else begin
            next_acc = acc + (W+CW)'(signed'(in_data));
            next_cnt = cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         acc       <= '0;
         cnt       <= '0;
         out_valid <= 1'b0;
         out_data  <= '0;
      end else begin
         acc       <= next_acc;
         cnt       <= next_cnt;
         out_valid <= next_out_valid;
         out_data  <= next_out_data;
      end
   end
endmodule
`default_nettype wire

// *** hw/temp_fmt_pkg.sv ***
// Constants for the temperature result formatter.
// Assumes a byte-wide register port driven by a serial bus front end.
package temp_fmt_pkg;
   localparam logic [7:0] OFS_LOCAL        = 8'h00;
   localparam logic [7:0] OFS_REMOTE_INT   = 8'h01;
   localparam logic [7:0] OFS_CONFIG_RD    = 8'h03;
   localparam logic [7:0] OFS_RATE_RD      = 8'h04;
   localparam logic [7:0] OFS_CONFIG_WR    = 8'h09;
   localparam logic [7:0] OFS_RATE_WR      = 8'h0A;
   localparam logic [7:0] OFS_REMOTE_FRAC  = 8'h10;
   localparam logic [7:0] OFS_LOC_HI_RD    = 8'h05;
   localparam logic [7:0] OFS_LOC_LO_RD    = 8'h06;
   localparam logic [7:0] OFS_REM_HI_RD    = 8'h07;
   localparam logic [7:0] OFS_REM_LO_RD    = 8'h08;
   localparam logic [7:0] OFS_LOC_HI_WR    = 8'h0B;
   localparam logic [7:0] OFS_LOC_LO_WR    = 8'h0C;
   localparam logic [7:0] OFS_REM_HI_WR    = 8'h0D;
   localparam logic [7:0] OFS_REM_LO_WR    = 8'h0E;
   localparam int         NUM_REGS         = 22;
   localparam int         RANGE_BIT        = 2;
   localparam int         STANDBY_BIT      = 6;
   localparam logic [7:0] CONFIG_RESET     = 8'h08;
   localparam logic [7:0] CONFIG_WR_MASK   = 8'hF4;
   localparam logic [7:0] RATE_RESET       = 8'h06;
   localparam logic [3:0] RATE_NO_AVG_MIN  = 4'h8;
   localparam logic [3:0] RATE_MAX_CODE    = 4'hA;
   localparam logic [7:0] LIMIT_HI_RESET   = 8'h55;
   localparam logic [7:0] LIMIT_LO_RESET   = 8'h00;
   localparam logic [7:0] RESULT_RESET     = 8'h00;
   localparam int         AVG_COUNT        = 16;
   localparam int         TEMP_OFFSET      = 64;
   localparam int         TEMP_MAX         = 125;
   localparam int         TEMP_MIN_EXT     = -40;
   localparam int         MEAS_W           = 12;
   localparam int         PHASE_CYCLES     = 8;
   typedef enum logic [1:0] {CUR_BASE, CUR_N1, CUR_N2} cur_sel_t;
endpackage

// *** hw/temperature_result_formatter.sv ***
// Digital back end of a dual-channel temperature sensor: sequencing,
// averaging, formatting and result registers behind a byte register port.
// Assumes a serial bus front end giving one-cycle read/write strobes and
// an ADC that answers each conversion start with a signed reading.
// Operation
// - Local result at 0x00, one degree steps
// - Remote integer at 0x01, fraction at 0x10
// - Fraction uses top two bits, quarter degrees
// - Fraction read freezes remote integer byte
// - Config bit 2 selects default/extended range
// - Valid result next cycle after range change
// - Default range reports plain unsigned binary
// - Extended range adds 64 degree offset
// - Plain binary clamps to 0 and 125
// - Next result written in new format
// - Range switch leaves limit registers untouched
// - Slow rates average 16 measurement cycles
// - Rates 10/20/36 per second not averaged
// - Remote current steps base, N1, N2
// - Compare results against channel high/low limits
// - Register space of 22 byte registers; 15 addresses decoded here, others read zero
// - Alternate local and remote conversions
// - Config read 0x03, written at 0x09
// - Results converter-written, host read-only, reset zero
`timescale 1ns/1ps
`default_nettype none
module temperature_result_formatter
   import temp_fmt_pkg::*;
#(
   parameter int MW = temp_fmt_pkg::MEAS_W
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Register port from the bus front end
   input  wire logic        reg_rd,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic [7:0]       reg_rdata,
   // Converter interface; reading in quarter degrees, signed
   output logic             conv_start,
   output logic             conv_remote,
   output logic [1:0]       cur_sel,
   input  wire logic        conv_done,
   input  wire logic [MW-1:0] conv_data,
   // Limit flags
   output logic             local_high,
   output logic             local_low,
   output logic             remote_high,
   output logic             remote_low
);
   import temp_fmt_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_BASE, S_N1, S_N2, S_WAIT} seq_t;

   // Convert quarter-degree reading to integer byte in chosen format
   function automatic logic [7:0] fmt_int(input logic signed [MW-1:0] q,
                                          input logic ext);
      logic signed [MW-1:0] deg;
      logic signed [MW-1:0] v;
      deg = q >>> 2;
      v   = '0;
      if (ext) begin
         v = deg;
         if (v < MW'(TEMP_MIN_EXT)) v = MW'(TEMP_MIN_EXT);
         if (v > MW'(TEMP_MAX)) v = MW'(TEMP_MAX);
         v = v + MW'(TEMP_OFFSET);
      end else begin
         v = deg;
         if (v < 0) v = '0;
         if (v > MW'(TEMP_MAX)) v = MW'(TEMP_MAX);
      end
      return v[7:0];
   endfunction

   // Fraction byte, zero once the integer part was clamped
   function automatic logic [7:0] fmt_frac(input logic signed [MW-1:0] q,
                                           input logic ext);
      logic signed [MW-1:0] deg;
      logic                 clamped;
      deg     = q >>> 2;
      clamped = (deg > MW'(TEMP_MAX)) ||
                (ext ? (deg < MW'(TEMP_MIN_EXT)) : (deg < 0));
      return clamped ? 8'h00 : {q[1:0], 6'h00};
   endfunction

   // Registers
   logic [7:0] local_result, next_local_result;
   logic [7:0] remote_int, next_remote_int;
   logic [7:0] remote_frac, next_remote_frac;
   logic [7:0] pend_int, next_pend_int;
   logic       pend_valid, next_pend_valid;
   logic       frozen, next_frozen;
   logic [7:0] config_reg, next_config_reg;
   logic [7:0] rate_reg, next_rate_reg;
   logic [7:0] lim_loc_hi, next_lim_loc_hi;
   logic [7:0] lim_loc_lo, next_lim_loc_lo;
   logic [7:0] lim_rem_hi, next_lim_rem_hi;
   logic [7:0] lim_rem_lo, next_lim_rem_lo;
   logic [7:0] next_reg_rdata;
   logic       next_local_high, next_local_low;
   logic       next_remote_high, next_remote_low;

   // Sequencer
   seq_t              state, next_state;
   logic [3:0]        tick, next_tick;
   logic              next_conv_start, next_conv_remote;
   logic [1:0]        next_cur_sel;
   logic signed [MW:0] sum_base, next_sum_base;
   logic              meas_valid, next_meas_valid;
   logic [MW-1:0]     meas_data, next_meas_data;
   logic              meas_remote, next_meas_remote;
   logic              avg_valid_l, avg_valid_r;
   logic [MW-1:0]     avg_data_l, avg_data_r;
   logic              bypass;
   logic              range_ext;
   logic              flush;
   logic              flush_l, next_flush_l, flush_r, next_flush_r;

   assign range_ext = config_reg[RANGE_BIT];
   assign bypass    = (rate_reg[3:0] >= RATE_NO_AVG_MIN) &&
                      (rate_reg[3:0] <= RATE_MAX_CODE);

   // Alternating channel sequence; remote uses three currents
   always_comb begin
      next_state       = state;
      next_tick        = tick;
      next_conv_start  = 1'b0;
      next_conv_remote = conv_remote;
      next_cur_sel     = cur_sel;
      next_sum_base    = sum_base;
      next_meas_valid  = 1'b0;
      next_meas_data   = meas_data;
      next_meas_remote = meas_remote;
      case (state)
         S_IDLE: begin
            if (!config_reg[STANDBY_BIT]) begin
               next_state      = S_BASE;
               next_cur_sel    = CUR_BASE;
               next_conv_start = 1'b1;
            end
         end
         S_BASE: begin
            if (conv_done) begin
               if (!conv_remote) begin
                  // Local channel: one reading is the measurement
                  next_meas_valid  = 1'b1;
                  next_meas_data   = conv_data;
                  next_meas_remote = 1'b0;
                  next_state       = S_WAIT;
               end else begin
                  next_sum_base   = (MW+1)'(signed'(conv_data));
                  next_cur_sel    = CUR_N1;
                  next_conv_start = 1'b1;
                  next_state      = S_N1;
               end
            end
         end
         S_N1: begin
            if (conv_done) begin
               next_sum_base   = sum_base + (MW+1)'(signed'(conv_data));
               next_cur_sel    = CUR_N2;
               next_conv_start = 1'b1;
               next_state      = S_N2;
            end
         end
         S_N2: begin
            if (conv_done) begin
               // Base, N1 and N2 readings summed and halved into one result
               next_meas_valid  = 1'b1;
               next_meas_data   = MW'((sum_base + (MW+1)'(signed'(conv_data))) >>> 1);
               next_meas_remote = 1'b1;
               next_cur_sel     = CUR_BASE;
               next_state       = S_WAIT;
            end
         end
         S_WAIT: begin
            next_tick = tick + 1'b1;
            if (tick == 4'(PHASE_CYCLES - 1)) begin
               next_tick        = '0;
               next_conv_remote = ~conv_remote;
               next_state       = S_IDLE;
            end
         end
         default: next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state       <= S_IDLE;
         tick        <= '0;
         conv_start  <= 1'b0;
         conv_remote <= 1'b0;
         cur_sel     <= CUR_BASE;
         sum_base    <= '0;
         meas_valid  <= 1'b0;
         meas_data   <= '0;
         meas_remote <= 1'b0;
      end else begin
         state       <= next_state;
         tick        <= next_tick;
         conv_start  <= next_conv_start;
         conv_remote <= next_conv_remote;
         cur_sel     <= next_cur_sel;
         sum_base    <= next_sum_base;
         meas_valid  <= next_meas_valid;
         meas_data   <= next_meas_data;
         meas_remote <= next_meas_remote;
      end
   end

   temp_avg #(.W(MW), .COUNT(AVG_COUNT)) u_avg_local (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .bypass    (bypass | flush | flush_l),
      .in_valid  (meas_valid & ~meas_remote),
      .in_data   (meas_data),
      .out_valid (avg_valid_l),
      .out_data  (avg_data_l)
   );

   temp_avg #(.W(MW), .COUNT(AVG_COUNT)) u_avg_remote (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .bypass    (bypass | flush | flush_r),
      .in_valid  (meas_valid & meas_remote),
      .in_data   (meas_data),
      .out_valid (avg_valid_r),
      .out_data  (avg_data_r)
   );

   // Range change restarts averaging so the next cycle is valid
   assign flush = reg_wr && (reg_addr == OFS_CONFIG_WR) &&
                  (reg_wdata[RANGE_BIT] != range_ext);

   // Register file and result update
   always_comb begin
      next_local_result = local_result;
      next_remote_int   = remote_int;
      next_remote_frac  = remote_frac;
      next_pend_int     = pend_int;
      next_pend_valid   = pend_valid;
      next_frozen       = frozen;
      next_config_reg   = config_reg;
      next_rate_reg     = rate_reg;
      next_lim_loc_hi   = lim_loc_hi;
      next_lim_loc_lo   = lim_loc_lo;
      next_lim_rem_hi   = lim_rem_hi;
      next_lim_rem_lo   = lim_rem_lo;
      next_reg_rdata    = reg_rdata;
      // Range change holds until each channel's next measurement
      next_flush_l      = (flush_l | flush) & ~(meas_valid & ~meas_remote);
      next_flush_r      = (flush_r | flush) & ~(meas_valid & meas_remote);
      if (avg_valid_l)
         next_local_result = fmt_int(avg_data_l, range_ext);
      // Unfreeze first so a same-cycle result still lands
      if (reg_rd && reg_addr == OFS_REMOTE_INT && frozen) begin
         next_frozen = 1'b0;
         if (pend_valid) begin
            next_remote_int = pend_int;
            next_pend_valid = 1'b0;
         end
      end
      // Fraction read pairs the integer byte with the fraction it returns
      if (reg_rd && reg_addr == OFS_REMOTE_FRAC) begin
         next_frozen     = 1'b1;
         next_pend_valid = 1'b0;
         if (pend_valid)
            next_remote_int = pend_int;
      end
      if (avg_valid_r) begin
         next_remote_frac = fmt_frac(avg_data_r, range_ext);
         if (next_frozen) begin
            next_pend_int   = fmt_int(avg_data_r, range_ext);
            next_pend_valid = 1'b1;
         end else begin
            next_remote_int = fmt_int(avg_data_r, range_ext);
         end
      end
      if (reg_wr) begin
         case (reg_addr)
            OFS_CONFIG_WR: next_config_reg = (reg_wdata & CONFIG_WR_MASK) |
                                             (CONFIG_RESET & ~CONFIG_WR_MASK);
            OFS_RATE_WR:   next_rate_reg   = {4'h0, reg_wdata[3:0]};
            // Limits change only here, never on a range switch
            OFS_LOC_HI_WR: next_lim_loc_hi = reg_wdata;
            OFS_LOC_LO_WR: next_lim_loc_lo = reg_wdata;
            OFS_REM_HI_WR: next_lim_rem_hi = reg_wdata;
            OFS_REM_LO_WR: next_lim_rem_lo = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            OFS_LOCAL:       next_reg_rdata = local_result;
            OFS_REMOTE_INT:  next_reg_rdata = remote_int;
            OFS_REMOTE_FRAC: next_reg_rdata = remote_frac;
            OFS_CONFIG_RD:   next_reg_rdata = config_reg;
            OFS_RATE_RD:     next_reg_rdata = rate_reg;
            OFS_LOC_HI_RD:   next_reg_rdata = lim_loc_hi;
            OFS_LOC_LO_RD:   next_reg_rdata = lim_loc_lo;
            OFS_REM_HI_RD:   next_reg_rdata = lim_rem_hi;
            OFS_REM_LO_RD:   next_reg_rdata = lim_rem_lo;
            default:         next_reg_rdata = 8'h00;
         endcase
      end
   end

   // Limit compare on stored results: high is >, low is <=
   always_comb begin
      next_local_high  = local_result > lim_loc_hi;
      next_local_low   = local_result <= lim_loc_lo;
      next_remote_high = remote_int > lim_rem_hi;
      next_remote_low  = remote_int <= lim_rem_lo;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         local_result <= RESULT_RESET;
         remote_int   <= RESULT_RESET;
         remote_frac  <= RESULT_RESET;
         pend_int     <= RESULT_RESET;
         pend_valid   <= 1'b0;
         frozen       <= 1'b0;
         flush_l      <= 1'b0;
         flush_r      <= 1'b0;
         config_reg   <= CONFIG_RESET;
         rate_reg     <= RATE_RESET;
         lim_loc_hi   <= LIMIT_HI_RESET;
         lim_loc_lo   <= LIMIT_LO_RESET;
         lim_rem_hi   <= LIMIT_HI_RESET;
         lim_rem_lo   <= LIMIT_LO_RESET;
         reg_rdata    <= 8'h00;
         local_high   <= 1'b0;
         local_low    <= 1'b0;
         remote_high  <= 1'b0;
         remote_low   <= 1'b0;
      end else begin
         local_result <= next_local_result;
         remote_int   <= next_remote_int;
         remote_frac  <= next_remote_frac;
         pend_int     <= next_pend_int;
         pend_valid   <= next_pend_valid;
         frozen       <= next_frozen;
         flush_l      <= next_flush_l;
         flush_r      <= next_flush_r;
         config_reg   <= next_config_reg;
         rate_reg     <= next_rate_reg;
         lim_loc_hi   <= next_lim_loc_hi;
         lim_loc_lo   <= next_lim_loc_lo;
         lim_rem_hi   <= next_lim_rem_hi;
         lim_rem_lo   <= next_lim_rem_lo;
         reg_rdata    <= next_reg_rdata;
         local_high   <= next_local_high;
         local_low    <= next_local_low;
         remote_high  <= next_remote_high;
         remote_low   <= next_remote_low;
      end
   end
endmodule
`default_nettype wire

// *** tb/adc_model.sv ***
// Converter and sensor model answering each conversion start.
// Assumes one-cycle start pulses; lat sets the answer delay (2..5).
`timescale 1ns/1ps
`default_nettype none
module adc_model #(
   parameter int MW = 12
) (
   // Clock
   input  wire logic                 mclk,
   // Requests
   input  wire logic                 conv_start,
   input  wire logic                 conv_remote,
   input  wire logic [1:0]           cur_sel,
   // Answer
   output logic                      conv_done,
   output logic [MW-1:0]             conv_data,
   // Scene
   input  wire logic signed [MW-1:0] temp_q,
   input  wire logic [2:0]           lat,
   input  wire logic                 dither
);
   logic          s, r, tog_l, tog_r;
   logic [1:0]    c;
   logic [MW-1:0] val;
   int            d;
   int            wait_n = -1;
   initial begin
      conv_done = 1'b0;
      conv_data = '0;
      tog_l = 1'b0;
      tog_r = 1'b0;
   end
   always @(posedge mclk) begin
      s = conv_start;
      r = conv_remote;
      c = cur_sel;
      // Later than the bench's input changes, so the scene is read settled
      #2;
      if (s) begin
         // Alternating offset cancels only over an even averaging window
         d = dither ? ((r ? tog_r : tog_l) ? 4 : -4) : 0;
         if (r && c == 2'h0) val = '0;
         else val = MW'(temp_q + d);
         if (!r) tog_l = ~tog_l;
         else if (c == 2'h2) tog_r = ~tog_r;
         wait_n = lat - 1;
      end
      if (wait_n == 0) begin
         conv_done = 1'b1;
         conv_data = val;
      end else begin
         // Data line wanders outside the answer cycle
         conv_done = 1'b0;
         conv_data = ~conv_data;
      end
      if (wait_n >= 0) wait_n--;
   end
endmodule
`default_nettype wire

// *** tb/temp_fmt_chk.sv ***
// Port-level properties of the temperature result formatter.
// Assumes binding onto the top module; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module temp_fmt_chk
   import temp_fmt_pkg::*;
#(
   parameter int MW = 12
) (
   // Clock and reset
   input wire logic          mclk,
   input wire logic          rst_n,
   // Register port
   input wire logic          reg_rd,
   input wire logic          reg_wr,
   input wire logic [7:0]    reg_addr,
   input wire logic [7:0]    reg_wdata,
   input wire logic [7:0]    reg_rdata,
   // Converter
   input wire logic          conv_start,
   input wire logic          conv_remote,
   input wire logic [1:0]    cur_sel,
   input wire logic          conv_done,
   input wire logic [MW-1:0] conv_data,
   // Flags
   input wire logic          local_high,
   input wire logic          local_low,
   input wire logic          remote_high,
   input wire logic          remote_low
);
   logic [7:0] cfg;
   logic [7:0] lhi;
   // Low limits stay at reset; bench never writes them
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= CONFIG_RESET;
         lhi <= LIMIT_HI_RESET;
      end else if (reg_wr) begin
         if (reg_addr == OFS_CONFIG_WR) cfg <= (reg_wdata & CONFIG_WR_MASK) | 8'h08;
         if (reg_addr == OFS_LOC_HI_WR) lhi <= reg_wdata;
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   AST_CFG_READ: assert property (
      reg_rd && reg_addr == OFS_CONFIG_RD |=> reg_rdata == cfg)
      else $error("config readback wrong");
   AST_FRAC_LOW: assert property (
      reg_rd && reg_addr == OFS_REMOTE_FRAC |=> reg_rdata[5:0] == 6'h00)
      else $error("fraction low bits not zero");
   AST_UNMAPPED: assert property (
      reg_rd && reg_addr == 8'hFF |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_BASE_N1: assert property (
      conv_done && conv_remote && cur_sel == CUR_BASE |=> ##[0:1] (conv_start && cur_sel == CUR_N1))
      else $error("no N1 step after base");
   AST_N1_N2: assert property (
      conv_done && conv_remote && cur_sel == CUR_N1 |=> ##[0:1] (conv_start && cur_sel == CUR_N2))
      else $error("no N2 step after N1");
   AST_REMOTE_LOCAL: assert property (
      conv_done && conv_remote && cur_sel == CUR_N2
      |=> (!conv_start) [*7] ##[1:12] (conv_start && !conv_remote))
      else $error("local conversion not next");
   AST_LOCAL_REMOTE: assert property (
      conv_done && !conv_remote
      |=> (!conv_start) [*7] ##[1:12] (conv_start && conv_remote && cur_sel == CUR_BASE))
      else $error("remote conversion not next");
   AST_LOC_FLAGS: assert property (
      reg_rd && reg_addr == OFS_LOCAL
      |=> local_high == (reg_rdata > lhi) && local_low == (reg_rdata <= LIMIT_LO_RESET))
      else $error("local limit flags wrong");
   AST_REM_FLAGS: assert property (
      reg_rd && reg_addr == OFS_REMOTE_INT
      |=> remote_high == (reg_rdata > LIMIT_HI_RESET) && remote_low == (reg_rdata <= LIMIT_LO_RESET))
      else $error("remote limit flags wrong");
   cover property (reg_rd && reg_addr == OFS_REMOTE_FRAC ##2 reg_rd && reg_addr == OFS_REMOTE_INT);
   cover property (conv_done && conv_remote && cur_sel == CUR_N2);
   cover property (reg_wr && reg_addr == OFS_CONFIG_WR && reg_wdata[RANGE_BIT]);
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the temperature result formatter.
// Assumes adc_model as converter and temp_fmt_chk bound below.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import temp_fmt_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_rd = 1'b0;
   logic reg_wr = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic conv_start, conv_remote, conv_done;
   logic local_high, local_low, remote_high, remote_low;
   logic [1:0] cur_sel;
   logic [MEAS_W-1:0] conv_data;
   logic signed [MEAS_W-1:0] temp_q = '0;
   logic [2:0] lat = 3'h2;
   logic dither = 1'b0;
   int failures = 0;
   int samples_checked = 0;
   int seed = 32'h98e67599;
   int q;
   int temps[$] = '{-161, -1, 0, 4, 101, 340, 500, 503, 504};
   always #4 mclk = ~mclk;
   temperature_result_formatter #(.MW(MEAS_W)) u_temperature_result_formatter (
      .mclk(mclk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .conv_start(conv_start), .conv_remote(conv_remote), .cur_sel(cur_sel),
      .conv_done(conv_done), .conv_data(conv_data), .local_high(local_high),
      .local_low(local_low), .remote_high(remote_high), .remote_low(remote_low));
   adc_model #(.MW(MEAS_W)) u_adc_model (
      .mclk(mclk), .conv_start(conv_start), .conv_remote(conv_remote),
      .cur_sel(cur_sel), .conv_done(conv_done), .conv_data(conv_data),
      .temp_q(temp_q), .lat(lat), .dither(dither));
   function automatic int deg(input int qq, input int e);
      int d;
      d = qq >>> 2;
      if (d > TEMP_MAX) d = TEMP_MAX;
      if (d < (e ? TEMP_MIN_EXT : 0)) d = e ? TEMP_MIN_EXT : 0;
      return e ? d + TEMP_OFFSET : d;
   endfunction
   function automatic int frac(input int qq, input int e);
      // Clamped results carry no fraction
      return ((qq >>> 2) == deg(qq, e) - (e ? TEMP_OFFSET : 0)) ? (qq & 3) << 6 : 0;
   endfunction
   task automatic summarize();
      $display("failures=%0d samples_checked=%0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [7:0] seen, input int exp);
      samples_checked++;
      if (seen !== 8'(exp)) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, 8'(exp), seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      @(posedge mclk);
      #1 reg_wr = 1'b0;
      @(posedge mclk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input int exp, input string name);
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge mclk);
      #1 reg_rd = 1'b0;
      @(posedge mclk);
      #1 check(name, reg_rdata, exp);
   endtask
   // Counts remote base-current starts; bounded so a stall ends the run
   task automatic rounds(input int n);
      int k;
      k = 0;
      for (int c = 0; c < 500 * n && k < n; c++) begin
         @(posedge mclk);
         if (conv_start === 1'b1 && conv_remote === 1'b1 && cur_sel === 2'h0) k++;
      end
      #1;
      if (k < n) begin
         failures++;
         $display("[ERR] rounds expected %0d seen %0d", n, k);
         summarize();
      end
   endtask
   task automatic check_all(input int qq, input int e);
      rd(OFS_LOCAL, deg(qq, e), "local");
      rd(OFS_REMOTE_FRAC, frac(qq, e), "frac");
      rd(OFS_REMOTE_INT, deg(qq, e), "int");
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      #1 rst_n = 1'b1;
      rd(OFS_LOCAL, 0, "local");
      rd(OFS_REMOTE_INT, 0, "int");
      rd(OFS_REMOTE_FRAC, 0, "frac");
      rd(OFS_CONFIG_RD, CONFIG_RESET, "config");
      rd(8'hFF, 0, "unmapped");
      wr(OFS_LOCAL, 8'h5A);
      rd(OFS_LOCAL, 0, "local ro");
      wr(OFS_RATE_WR, 8'h08);
      rd(OFS_RATE_RD, 8'h08, "rate");
      for (int i = 0; i < 4; i++) temps.push_back($random(seed) % 700);
      for (int e = 0; e < 2; e++) begin
         wr(OFS_CONFIG_WR, e ? 8'h04 : 8'h00);
         rd(OFS_LOC_HI_RD, LIMIT_HI_RESET, "limit");
         foreach (temps[i]) begin
            temp_q = MEAS_W'(temps[i]);
            lat = 3'(2 + ($random(seed) & 3));
            rounds(2);
            check_all(temps[i], e);
         end
      end
      q = 161;
      temp_q = MEAS_W'(q);
      rounds(2);
      rd(OFS_REMOTE_FRAC, frac(q, 1), "frac");
      temp_q = MEAS_W'(282);
      rounds(2);
      rd(OFS_REMOTE_INT, deg(q, 1), "frozen int");
      rd(OFS_REMOTE_INT, deg(282, 1), "released int");
      rd(OFS_REMOTE_FRAC, frac(282, 1), "frac");
      wr(OFS_LOC_HI_WR, 8'h50);
      wr(OFS_RATE_WR, 8'h06);
      q = 222;
      temp_q = MEAS_W'(q);
      dither = 1'b1;
      rounds(34);
      // Cleared early so no dithered reading meets the flush below
      dither = 1'b0;
      check_all(q, 1);
      wr(OFS_CONFIG_WR, 8'h00);
      rounds(2);
      check_all(q, 0);
      rd(OFS_LOC_HI_RD, 8'h50, "limit");
      summarize();
   end
endmodule
bind temperature_result_formatter temp_fmt_chk #(.MW(MW)) u_temp_fmt_chk (
   .mclk(mclk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_start(conv_start),
   .conv_remote(conv_remote), .cur_sel(cur_sel), .conv_done(conv_done),
   .conv_data(conv_data), .local_high(local_high), .local_low(local_low),
   .remote_high(remote_high), .remote_low(remote_low));
`default_nettype wire
